// File: hdl/sar_pkg.sv
// Purpose: Shared constants and types for the SAR converter sequencer.
// Assumes: One clock, hclk at 250 MHz; registers reached over AHB-Lite.
// Notes: Byte offsets are word aligned; data is 32 bits wide.
// Functional notes
// - Strobe high starts a temperature reading.
// - Diode current high when strobe low.
// - Ten-bit temperature code equals kelvin.
// - Eight-bit four kelvin; twelve-bit a quarter.
// - Example codes such as 298 K.
// - Sense pin voltage mode: two ranges, positive.
// - Resolution selectable 8, 10 or 12.
// - Results are MSB-justified.
// - Channel select picks one of 32.
// - Calibrate at power-up and after samples.
// - Discharge, acquire, ground, then decide.
// - First decision against half reference.
// - Keep or release bit, add next.
// - Conversion takes acquisition plus N+1 cycles.
// - One count is reference over 2^N.
// - Sampling indication drops when sampling ends.
package sar_pkg;
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_SAMPLE = 8'h04;
   localparam logic [7:0] ADDR_RESULT = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   // Control fields.
   localparam int CTRL_START_BIT  = 0;
   localparam int CTRL_RES_LSB    = 1;
   localparam int CTRL_CHAN_LSB   = 3;
   localparam int CTRL_TEMP_BIT   = 8;
   localparam int CTRL_RANGE_BIT  = 9;
   localparam int CTRL_VMODE_BIT  = 10;
   localparam int CHAN_W          = 5;
   localparam int RES_MAX         = 12;
   localparam logic [7:0]  SAMPLE_RST   = 8'h04;
   localparam logic [31:0] CTRL_RST     = 32'h0000_0002;
   // Power-up calibration counter load; calibration lasts one cycle more.
   localparam logic [7:0]  CAL_CYCLES   = 8'h10;
   localparam logic [7:0]  DCAL_CYCLES  = 8'h02;
   localparam logic [7:0]  DISCH_CYCLES = 8'h01;
   typedef enum logic [1:0] {RES_8 = 2'h0, RES_10 = 2'h1,
                             RES_12 = 2'h2} res_e;
   typedef enum logic [7:0] {
      ST_CAL    = 8'h01, ST_IDLE = 8'h02, ST_DISCH = 8'h04,
      ST_ACQ    = 8'h08, ST_GND  = 8'h10, ST_BITS  = 8'h20,
      ST_DONE   = 8'h40, ST_DCAL = 8'h80
   } sar_state_e;
   typedef struct packed {
      logic       sample;
      logic       done;
      logic       busy;
      logic [11:0] result;
   } sar_stat_s;
endpackage : sar_pkg

// File: hdl/sar_bit_steer.sv
// Purpose: Successive approximation trial register for up to 12 bits.
// Assumes: Comparator input valid each decision cycle.
// Notes: Trial code is MSB-justified in the 12-bit field.
`timescale 1ns/1ps
module sar_bit_steer
   import sar_pkg::*;
#(
   parameter int W = RES_MAX
)(
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic         init,
   input  wire logic         step,
   input  wire logic         comp_hi,
   output logic [W-1:0]      trial,
   output logic [W-1:0]      code
);
   logic [W-1:0] ptr_r;
   logic [W-1:0] code_r;
   logic [W-1:0] code_nxt;
   logic [W-1:0] ptr_nxt;
   // Each bit is kept when the comparator is high, else released.
   genvar g;
   generate
      for (g = 0; g < W; g++)
      begin : g_bit
         assign code_nxt[g] = ptr_r[g] ? comp_hi : code_r[g];
      end
   endgenerate
   assign ptr_nxt = ptr_r >> 1;
   assign trial   = code_r | ptr_r;
   assign code    = code_r;
   // Pointer starts at the MSB, half the reference.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ptr_r  <= '0;
         code_r <= '0;
      end
      else if (init)
      begin
         ptr_r  <= {1'b1, {(W-1){1'b0}}};
         code_r <= '0;
      end
      else if (step)
      begin
         ptr_r  <= ptr_nxt;
         code_r <= code_nxt;
      end
   end
endmodule : sar_bit_steer

// File: hdl/sar_sequencer.sv
// Purpose: Sequencer for the SAR converter and temperature channel.
// Assumes: Comparator output comp_hi is synchronous to hclk.
// Notes: AHB-Lite slave with zero wait states and OKAY answers.
//
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module sar_sequencer
   import sar_pkg::*;
(
   input  wire logic          hclk,
   input  wire logic          hresetn,
   input  wire logic          hsel,
   input  wire logic [7:0]    haddr,
   input  wire logic [1:0]    htrans,
   input  wire logic          hwrite,
   input  wire logic [2:0]    hsize,
   input  wire logic [31:0]   hwdata,
   input  wire logic          hready,
   output logic [31:0]        hrdata,
   output logic               hreadyout,
   output logic               hresp,
   input  wire logic          temp_strobe,
   input  wire logic          conversion_request,
   input  wire logic          comp_hi,
   output logic               diode_high_current,
   output logic [4:0]         mux_select,
   output logic               cap_discharge,
   output logic               cap_connect_input,
   output logic               cap_ground,
   output logic [11:0]        dac_trial,
   output logic               sense_range_16v,
   output logic               sample_active,
   output logic [11:0]        conversion_result,
   output logic               conversion_done,
   output logic               calibrating
);
   sar_state_e  state_r;
   sar_state_e  state_nxt;
   logic [31:0] ctrl_r;
   logic [7:0]  sample_r;
   logic [7:0]  cnt_r;
   logic [7:0]  cnt_nxt;
   logic [3:0]  bits_r;
   logic [11:0] result_r;
   logic        done_r;
   logic        strobe_seen_r;
   logic        start_pend_r;
   logic        wr_pend_r;
   logic        rd_pend_r;
   logic [7:0]  addr_r;
   logic [11:0] trial;
   logic [11:0] code;
   logic [11:0] code_mask;
   logic [11:0] code_after;
   logic [11:0] trial_next;
   logic [3:0]  nbits;
   logic        addr_ok;
   logic        start_req;
   logic        strobe_rise;
   logic        bit_init;
   logic        bit_step;
   logic        cnt_zero;
   logic [31:0] rdata_nxt;
   logic        hit_ctrl;
   logic        hit_sample;
   logic        hit_result;
   logic        hit_status;
   res_e        res_sel;

   // Bus address phase decode.
   assign addr_ok    = hsel & htrans[1] & hready;
   assign hit_ctrl   = addr_r == ADDR_CTRL;
   assign hit_sample = addr_r == ADDR_SAMPLE;
   assign hit_result = addr_r == ADDR_RESULT;
   assign hit_status = addr_r == ADDR_STATUS;

   // Resolution select and bit count; 12 when undefined.
   assign res_sel = res_e'(ctrl_r[CTRL_RES_LSB +: 2]);
   assign nbits   = (res_sel == RES_8)  ? 4'h8 :
                    (res_sel == RES_10) ? 4'hA : 4'hC;
   // Bits below the selected resolution read as zero.
   // In ten-bit mode the kept field reads one count per kelvin.
   assign code_mask = (res_sel == RES_8)  ? 12'hFF0 :
                      (res_sel == RES_10) ? 12'hFFC : 12'hFFF;

   // Code once the current decision is applied: the trial bit is kept
   // when the comparator is high, else the bit is released.
   assign code_after = comp_hi ? trial : code;
   // Trial the converter sees next, so the registered trial output and
   // the comparator answer always belong to the same decision cycle.
   assign trial_next = bit_init ? {1'b1, {(RES_MAX-1){1'b0}}} :
                       bit_step ? (code_after | ((trial ^ code) >> 1)) :
                       trial;

   // A start comes from software, the request pin or a strobe rise.
   assign strobe_rise = temp_strobe & ~strobe_seen_r;
   assign start_req   = start_pend_r | conversion_request | strobe_rise;
   assign cnt_zero    = cnt_r == 8'h00;
   assign bit_init    = (state_r == ST_GND);
   assign bit_step    = (state_r == ST_BITS) & (bits_r != 4'h0);

   sar_bit_steer #(
      .W (RES_MAX)
   ) u_steer (
      .hclk    (hclk),
      .hresetn (hresetn),
      .init    (bit_init),
      .step    (bit_step),
      .comp_hi (comp_hi),
      .trial   (trial),
      .code    (code)
   );

   // Conversion state machine.
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt   = cnt_zero ? 8'h00 : cnt_r - 8'h01;
      case (state_r)
         ST_CAL:
            if (cnt_zero)
               state_nxt = ST_IDLE;
         ST_IDLE:
            if (start_req)
            begin
               state_nxt = ST_DISCH;
               cnt_nxt   = DISCH_CYCLES - 8'h01;
            end
         ST_DISCH:
            if (cnt_zero)
            begin
               state_nxt = ST_ACQ;
               cnt_nxt   = sample_r - 8'h01;
            end
         ST_ACQ:
            if (cnt_zero)
               state_nxt = ST_GND;
         ST_GND:
            state_nxt = ST_BITS;
         ST_BITS:
            if (bits_r == 4'h0)
               state_nxt = ST_DONE;
         ST_DONE:
         begin
            state_nxt = ST_DCAL;
            cnt_nxt   = DCAL_CYCLES - 8'h01;
         end
         ST_DCAL:
            if (cnt_zero)
               state_nxt = ST_IDLE;
         default:
            state_nxt = ST_IDLE;
      endcase
   end

   // State, counters and bit count.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_r <= ST_CAL;
         cnt_r   <= CAL_CYCLES;
         bits_r  <= 4'h0;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         if (state_r == ST_GND)
            bits_r <= nbits - 4'h1;
         else if (bit_step)
            bits_r <= bits_r - 4'h1;
      end
   end

   // Result capture and one-cycle done pulse after the LSB.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         result_r <= 12'h000;
         done_r   <= 1'b0;
      end
      else
      begin
         done_r <= (state_r == ST_BITS) & (bits_r == 4'h0);
         if ((state_r == ST_BITS) & (bits_r == 4'h0))
            result_r <= code_after & code_mask;
      end
   end

   // Strobe edge memory and pending software start.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         strobe_seen_r <= 1'b0;
         start_pend_r  <= 1'b0;
      end
      else
      begin
         strobe_seen_r <= temp_strobe;
         if (wr_pend_r & hit_ctrl & hwdata[CTRL_START_BIT])
            start_pend_r <= 1'b1;
         else if (state_r == ST_IDLE)
            start_pend_r <= 1'b0;
      end
   end

   // Bus data phase tracking.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         addr_r    <= 8'h00;
      end
      else
      begin
         wr_pend_r <= addr_ok & hwrite;
         rd_pend_r <= addr_ok & ~hwrite;
         if (addr_ok)
            addr_r <= {haddr[7:2], 2'b00};
      end
   end

   // Control and sample time registers.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_r   <= CTRL_RST;
         sample_r <= SAMPLE_RST;
      end
      else if (wr_pend_r)
      begin
         if (hit_ctrl)
            ctrl_r <= {21'h0, hwdata[10:1], 1'b0};
         if (hit_sample)
            sample_r <= (hwdata[7:0] == 8'h00) ? 8'h01 : hwdata[7:0];
      end
   end

   // Read mux; unmapped offsets read zero.
   always_comb
   begin
      rdata_nxt = 32'h0000_0000;
      if (hit_ctrl)
         rdata_nxt = ctrl_r;
      else if (hit_sample)
         rdata_nxt = {24'h0, sample_r};
      else if (hit_result)
         rdata_nxt = {20'h0, result_r};
      else if (hit_status)
         rdata_nxt = {16'h0, state_r == ST_CAL, sample_active,
                      state_r != ST_IDLE, 1'b0, result_r};
   end

   assign hrdata    = rd_pend_r ? rdata_nxt : 32'h0000_0000;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // Analog control outputs, all registered.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         diode_high_current <= 1'b1;
         mux_select         <= 5'h00;
         cap_discharge      <= 1'b0;
         cap_connect_input  <= 1'b0;
         cap_ground         <= 1'b0;
         dac_trial          <= 12'h000;
         sense_range_16v    <= 1'b0;
         sample_active      <= 1'b0;
         calibrating        <= 1'b1;
      end
      else
      begin
         diode_high_current <= ~temp_strobe;
         mux_select         <= ctrl_r[CTRL_CHAN_LSB +: CHAN_W];
         cap_discharge      <= state_nxt == ST_DISCH;
         cap_connect_input  <= state_nxt == ST_ACQ;
         cap_ground         <= state_nxt == ST_GND;
         dac_trial          <= trial_next;
         sense_range_16v    <= ctrl_r[CTRL_VMODE_BIT]
                               & ctrl_r[CTRL_RANGE_BIT];
         sample_active      <= state_nxt == ST_ACQ;
         calibrating        <= (state_nxt == ST_CAL)
                               | (state_nxt == ST_DCAL);
      end
   end

   assign conversion_result = result_r;
   assign conversion_done   = done_r;
endmodule : sar_sequencer

// File: verif/sar_sequencer_assertions.sv
// Purpose: Port checker for the SAR converter sequencer.
// Assumes: One clock domain, reset active low.
// Notes: Bound onto every sar_sequencer instance.
`timescale 1ns/1ps
module sar_sequencer_assertions (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic temp_strobe,
   input wire logic diode_high_current,
   input wire logic cap_discharge,
   input wire logic cap_connect_input,
   input wire logic cap_ground,
   input wire logic sample_active,
   input wire logic conversion_done,
   input wire logic calibrating
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Bus answers, diode current and conversion phases.
   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer is not ready and OKAY");
   chk_diode_low: assert property (temp_strobe |=> !diode_high_current)
      else $error("diode current not low with strobe high");
   chk_diode_high: assert property (!temp_strobe |=> diode_high_current)
      else $error("diode current not high with strobe low");
   chk_disch_acq: assert property (cap_discharge |=> cap_connect_input)
      else $error("acquisition does not follow discharge");
   chk_acq_ground: assert property ($fell(cap_connect_input) |-> cap_ground)
      else $error("capacitors not grounded after acquisition");
   chk_phase_excl: assert property
      ($onehot0({cap_discharge, cap_connect_input, cap_ground}))
      else $error("two capacitor phases at once");
   chk_sample_acq: assert property (sample_active == cap_connect_input)
      else $error("sampling indication differs from acquisition");
   chk_ground_once: assert property (cap_ground |=> !cap_ground)
      else $error("ground phase longer than one cycle");
   chk_bits_early: assert property
      ($fell(cap_ground) |-> !conversion_done [*7])
      else $error("conversion finished too early");
   chk_bits_late: assert property
      ($fell(cap_ground) |-> ##[8:13] conversion_done)
      else $error("conversion finished too late");
   chk_done_pulse: assert property (conversion_done |=> !conversion_done)
      else $error("done indication longer than one cycle");
   chk_done_cal: assert property (conversion_done |-> ##[1:2] calibrating)
      else $error("no calibration after a sample");
   // Main scenarios reached.
   cov_done: cover property (conversion_done);
   cov_strobe: cover property ($rose(temp_strobe));
   cov_sample: cover property (sample_active ##1 !sample_active);
endmodule : sar_sequencer_assertions

bind sar_sequencer sar_sequencer_assertions i_sar_sequencer_assertions (
   .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
   .temp_strobe(temp_strobe), .diode_high_current(diode_high_current),
   .cap_discharge(cap_discharge), .cap_connect_input(cap_connect_input),
   .cap_ground(cap_ground), .sample_active(sample_active),
   .conversion_done(conversion_done), .calibrating(calibrating));

// File: verif/comp_model.sv
// Purpose: Behavioural comparator standing for the analog front end.
// Assumes: Input level vin is given in counts of the 12-bit field.
// Notes: Answers the trial code within the same cycle.
`timescale 1ns/1ps
module comp_model (
   input  wire logic [11:0] vin,
   input  wire logic [11:0] dac_trial,
   output logic             comp_hi
);
   // A trial at or below the input level keeps its bit set.
   assign comp_hi = (vin >= dac_trial);
endmodule : comp_model

// File: verif/temp_monitor_sar_adc_sequencer_tb.sv
// Purpose: Self-checking bench for the SAR converter sequencer.
// Assumes: Zero wait AHB-Lite slave; comparator model on the far side.
// Notes: Expected codes are worked out from the input level.
`timescale 1ns/1ps
module temp_monitor_sar_adc_sequencer_tb;
   import sar_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hready, hresp, hreadyout;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, rd;
   logic        temp_strobe, conv_req, comp_hi, diode_hi, done, cal;
   logic        cap_d, cap_c, cap_g, range16, sample_active;
   logic [4:0]  mux_select;
   logic [11:0] vin, trial, result, res, m;
   int          errors, n_compared, cyc, n_acq;
   int          kel [4] = '{233, 273, 298, 358};
   logic [9:0]  code [4] = '{10'h0E9, 10'h111, 10'h12A, 10'h166};

   // Clock and single slave ready loop.
   initial
   begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   assign hready = hreadyout;

   sar_sequencer i_sar_sequencer (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .temp_strobe(temp_strobe),
      .conversion_request(conv_req), .comp_hi(comp_hi),
      .diode_high_current(diode_hi), .mux_select(mux_select),
      .cap_discharge(cap_d), .cap_connect_input(cap_c),
      .cap_ground(cap_g), .dac_trial(trial), .sense_range_16v(range16),
      .sample_active(sample_active), .conversion_result(result),
      .conversion_done(done), .calibrating(cal));

   comp_model i_comp_model (.vin(vin), .dac_trial(trial), .comp_hi(comp_hi));

   // One single-word transfer: address phase, then data phase.
   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rdat);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      hsize <= 3'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rdat = hrdata;
   endtask : ahb

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // Waits for the done pulse and counts cycles spent sampling.
   task automatic wait_done(output logic [11:0] r);
      int n;
      n = 0;
      n_acq = 0;
      while (done !== 1'b1 && n < 300)
      begin
         @(posedge hclk);
         n++;
         if (sample_active === 1'b1) n_acq++;
      end
      if (n >= 300)
         errors++;
      r = result;
   endtask : wait_done

   task automatic wait_idle;
      do ahb(1'b0, ADDR_STATUS, 32'h0, rd);
      while (rd[15] !== 1'b0 || rd[13] !== 1'b0);
   endtask : wait_idle

   // Software start: ctl carries the start bit.
   task automatic conv(input logic [31:0] ctl, input logic [11:0] exp);
      wait_idle();
      ahb(1'b1, ADDR_CTRL, ctl, rd);
      wait_done(res);
      check(res, exp);
   endtask : conv

   // Fabric start by strobe or request, held until the result is out.
   task automatic pin_conv(input logic [31:0] ctl, input logic use_req);
      wait_idle();
      ahb(1'b1, ADDR_CTRL, ctl, rd);
      if (use_req) conv_req <= 1'b1;
      else temp_strobe <= 1'b1;
      wait_done(res);
      conv_req <= 1'b0;
      temp_strobe <= 1'b0;
   endtask : pin_conv

   task automatic tally_and_finish;
      $display("compared=%0d errors=%0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish

   // Hang guard.
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         errors++;
         tally_and_finish();
      end
   end

   // Test sequence.
   initial
   begin
      {hsel, hwrite, temp_strobe, conv_req, hresetn} = '0;
      haddr = '0;
      htrans = '0;
      hsize = '0;
      hwdata = '0;
      vin = 12'hA5C;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check(cal, 1'b1);
      ahb(1'b0, ADDR_CTRL, 32'h0, rd);
      check(rd, CTRL_RST);
      ahb(1'b0, ADDR_SAMPLE, 32'h0, rd);
      check(rd, {24'h0, SAMPLE_RST});
      ahb(1'b1, 8'h10, 32'hFFFF_FFFF, rd);
      ahb(1'b0, 8'h10, 32'h0, rd);
      check(rd, 32'h0);
      $display("test reset_values done");
      for (int r = 0; r < 3; r++)
      begin
         m = 12'hFFF << (4 - 2 * r);
         conv(32'h29 | (r << 1), vin & m);
         check(mux_select, 5'h05);
         ahb(1'b0, ADDR_RESULT, 32'h0, rd);
         check(rd[11:0], vin & m);
      end
      $display("test resolutions done");
      ahb(1'b1, ADDR_SAMPLE, 32'h3, rd);
      ahb(1'b0, ADDR_SAMPLE, 32'h0, rd);
      check(rd, 32'h3);
      vin = 12'h001;
      conv(32'h5, 12'h001);
      check(n_acq, 3);
      vin = 12'hFFF;
      conv(32'h5, 12'hFFF);
      $display("test sample_time done");
      for (int i = 0; i < 4; i++)
      begin
         vin = 12'(kel[i] * 4);
         pin_conv(32'h102, 1'b0);
         check(res[11:2], code[i]);
      end
      vin = 12'h4A8;
      pin_conv(32'h100, 1'b0);
      check(res, 12'h4A0);
      wait_idle();
      check(diode_hi, 1'b1);
      $display("test temperature done");
      vin = 12'h7FF;
      pin_conv(32'h6FC, 1'b1);
      check(res, 12'h7FF);
      check(mux_select, 5'h1F);
      check(range16, 1'b1);
      $display("test request done");
      tally_and_finish();
   end
endmodule : temp_monitor_sar_adc_sequencer_tb
